// file: tlic_pkg.sv
// constants and types of the two-level interrupt controller
package tlic_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NSRC = 8;
    localparam int NPIN = 2;
    localparam int AW   = 8;
    localparam int VW   = 21;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_RCR  = 8'h00;
    localparam logic [AW-1:0] ADDR_ICR  = 8'h04;
    localparam logic [AW-1:0] ADDR_FLAG = 8'h08;
    localparam logic [AW-1:0] ADDR_EN   = 8'h0c;
    localparam logic [AW-1:0] ADDR_PRIO = 8'h10;
    localparam logic [AW-1:0] ADDR_PERI = 8'h14;
    localparam logic [AW-1:0] ADDR_STAT = 8'h18;

    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int         BIT_PM  = 7;
    localparam int         BIT_GH  = 7;
    localparam int         BIT_GL  = 6;
    localparam logic [7:0] MASK_GH = 8'h80;
    localparam logic [7:0] MASK_GL = 8'h40;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RCR  = 8'h00;
    localparam logic [7:0] RST_ICR  = 8'h00;
    localparam logic [7:0] RST_FLAG = 8'h00;
    localparam logic [7:0] RST_EN   = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'hff;
    localparam logic [7:0] RST_PERI = 8'hfc;

    // ------------------------------------------------------------
    // vectors and latency
    // ------------------------------------------------------------
    localparam logic [VW-1:0] VEC_HIGH    = 21'h000008;
    localparam logic [VW-1:0] VEC_LOW     = 21'h000018;
    localparam logic [1:0]    INT_LAT_CYC = 2'h3;

    typedef enum logic [0:0] {st_idle, st_wait} tlic_state_type;

    // address match, used by read mux and write strobes
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] off);
        hit = (a == off);
    endfunction

endpackage

// file: tlic_pin_sync.sv
// external pin synchroniser with rising edge event
`timescale 1ns/1ps
module tlic_pin_sync
(
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic [tlic_pkg::NPIN-1:0] pin_in,
    output logic      [tlic_pkg::NPIN-1:0] pin_evt
);
    import tlic_pkg::*;

    logic [NPIN-1:0] s1_r;
    logic [NPIN-1:0] s2_r;
    logic [NPIN-1:0] s3_r;
    logic [NPIN-1:0] lvl_r;
    logic [NPIN-1:0] agree;

    // -------------------------------------------------------------
    // change counts once second and third stage agree
    // -------------------------------------------------------------
    assign agree = ~(s2_r ^ s3_r);

    // three stages, filtered level, one-cycle rising event
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            lvl_r   <= '0;
            pin_evt <= '0;
        end
        else
        begin
            s1_r    <= pin_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            lvl_r   <= (agree & s3_r) | (~agree & lvl_r);
            pin_evt <= agree & s3_r & ~lvl_r;
        end
    end

endmodule

// file: tlic_ctrl.sv
// two-level priority interrupt controller with apb registers
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

// Contract
// - priority mode: high to 000008h, low 000018h
// - pending high preempts running low routine
// - each source has flag, enable, priority
// - priority mode only while mode bit set
// - priority mode: bit 7 gates high sources
// - priority mode: bit 6 gates low sources
// - flag, enable, global enable vector immediately
// - mode bit clear: priority bits ignored
// - compat: bit 6 peripherals, bit 7 all
// - compat: every interrupt vectors to 000008h
// - acceptance clears the governing global enable
// - no low accepted while high serviced
// - acceptance pushes return, loads vector
// - return instruction sets applicable global enable
// - pin interrupt latency three to four cycles; here seven to eight cycles from pin change to pc_load
// - flags set regardless of any enable
module tlic_ctrl
(
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [tlic_pkg::AW-1:0]   paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [tlic_pkg::NSRC-1:0] src_evt,
    input  wire logic [tlic_pkg::NPIN-1:0] ext_pin,
    input  wire logic                      return_from_interrupt_instr,
    output logic                           irq_req,
    output logic                           stack_push,
    output logic                           pc_load,
    output logic      [tlic_pkg::VW-1:0]   vec_addr
);
    import tlic_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]     rcr_r;
    logic [7:0]     icr_r;
    logic [7:0]     flag_r;
    logic [7:0]     en_r;
    logic [7:0]     prio_r;
    logic [7:0]     peri_r;
    logic           in_high_r;
    logic           in_low_r;
    logic           take_hi_r;
    tlic_state_type st_r;
    logic [1:0]     cnt_r;
    logic [NPIN-1:0] pin_evt;

    logic           pm;
    logic           gh;
    logic           gl;
    logic [7:0]     pend;
    logic           hi_pm;
    logic           lo_pm;
    logic           cp_req;
    logic           hi_req;
    logic           lo_req;
    logic           req;
    logic           take;
    logic [7:0]     evts;
    logic [7:0]     flag_nxt;
    logic [7:0]     icr_w;
    logic [7:0]     ret_set;
    logic [7:0]     tk_clr;
    logic [7:0]     icr_nxt;
    logic           acc;
    logic           wr;
    logic           mapped;
    logic [31:0]    rdata;
    logic           in_high_nxt;
    logic           in_low_nxt;

    // ------------------------------------------------------------
    // external pins
    // ------------------------------------------------------------
    tlic_pin_sync u_pin_sync
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .pin_in  (ext_pin),
        .pin_evt (pin_evt)
    );

    // ------------------------------------------------------------
    // qualification
    // ------------------------------------------------------------
    // mode and global enables
    assign pm   = rcr_r[BIT_PM];
    assign gh   = icr_r[BIT_GH];
    assign gl   = icr_r[BIT_GL];
    assign pend = flag_r & en_r;

    // priority mode requests per level
    assign hi_pm = gh & |(pend & prio_r);
    assign lo_pm = gl & ~in_high_r & |(pend & ~prio_r);
    // compat: bit 6 gates peripherals, bit 7 everything
    assign cp_req = gh & |(pend & (~peri_r | {8{gl}}));

    // level select, high wins a tie
    assign hi_req = pm ? hi_pm : cp_req;
    assign lo_req = pm & lo_pm;
    assign req    = hi_req | lo_req;

    // fixed acceptance point, independent of instruction length
    assign take = (st_r == st_wait) && req &&
                  (cnt_r == INT_LAT_CYC - 2'h1);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign acc    = psel & penable;
    assign wr     = acc & pready & pwrite;
    assign mapped = hit(paddr, ADDR_RCR) | hit(paddr, ADDR_ICR) |
                    hit(paddr, ADDR_FLAG) | hit(paddr, ADDR_EN) |
                    hit(paddr, ADDR_PRIO) | hit(paddr, ADDR_PERI) |
                    hit(paddr, ADDR_STAT);

    // read mux
    assign rdata =
        hit(paddr, ADDR_RCR)  ? {24'h0, rcr_r}  :
        hit(paddr, ADDR_ICR)  ? {24'h0, icr_r}  :
        hit(paddr, ADDR_FLAG) ? {24'h0, flag_r} :
        hit(paddr, ADDR_EN)   ? {24'h0, en_r}   :
        hit(paddr, ADDR_PRIO) ? {24'h0, prio_r} :
        hit(paddr, ADDR_PERI) ? {24'h0, peri_r} :
        hit(paddr, ADDR_STAT) ? {28'h0, st_r == st_wait, irq_req,
                                 in_low_r, in_high_r} : 32'h0;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    // flags: events set, write-one clears, set wins
    assign evts     = src_evt | {{(NSRC-NPIN){1'b0}}, pin_evt};
    assign flag_nxt = (flag_r & ~((wr && hit(paddr, ADDR_FLAG)) ?
                      pwdata[7:0] : 8'h00)) | evts;

    // global enables: write, then return sets, then take clears
    assign icr_w   = (wr && hit(paddr, ADDR_ICR)) ? pwdata[7:0] : icr_r;
    assign ret_set = !return_from_interrupt_instr ? 8'h00 :
                     !pm       ? MASK_GH :
                     in_high_r ? MASK_GH :
                     in_low_r  ? MASK_GL : 8'h00;
    assign tk_clr  = !take ? 8'h00 :
                     (pm & ~hi_req) ? MASK_GL : MASK_GH;
    assign icr_nxt = (icr_w | ret_set) & ~tk_clr;

    // service level: return leaves innermost, take enters
    assign in_high_nxt = (in_high_r & ~return_from_interrupt_instr) |
                         (take & hi_req);
    assign in_low_nxt  = (in_low_r & ~(return_from_interrupt_instr &
                         ~in_high_r)) | (take & ~hi_req);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // software controls and flags
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rcr_r  <= RST_RCR;
            icr_r  <= RST_ICR;
            flag_r <= RST_FLAG;
            en_r   <= RST_EN;
            prio_r <= RST_PRIO;
            peri_r <= RST_PERI;
        end
        else
        begin
            if (wr && hit(paddr, ADDR_RCR))
                rcr_r <= pwdata[7:0] & MASK_GH;
            if (wr && hit(paddr, ADDR_EN))
                en_r <= pwdata[7:0];
            if (wr && hit(paddr, ADDR_PRIO))
                prio_r <= pwdata[7:0];
            if (wr && hit(paddr, ADDR_PERI))
                peri_r <= pwdata[7:0];
            icr_r  <= icr_nxt;
            flag_r <= flag_nxt;
        end
    end

    // acceptance sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_r  <= st_idle;
            cnt_r <= 2'h0;
        end
        else
        begin
            unique case (st_r)
                st_idle:
                begin
                    if (req)
                    begin
                        st_r  <= st_wait;
                        cnt_r <= 2'h1;
                    end
                end
                st_wait:
                begin
                    if (!req || take)
                        st_r <= st_idle;
                    cnt_r <= cnt_r + 2'h1;
                end
            endcase
        end
    end

    // core strobes: push return address, load vector
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            in_high_r  <= 1'b0;
            in_low_r   <= 1'b0;
            take_hi_r  <= 1'b0;
            irq_req    <= 1'b0;
            stack_push <= 1'b0;
            pc_load    <= 1'b0;
            vec_addr   <= VEC_HIGH;
        end
        else
        begin
            in_high_r  <= in_high_nxt;
            in_low_r   <= in_low_nxt;
            irq_req    <= req;
            stack_push <= take;
            pc_load    <= take;
            if (take)
            begin
                take_hi_r <= hi_req;
                vec_addr  <= hi_req ? VEC_HIGH : VEC_LOW;
            end
        end
    end

    // apb answer: one wait state, error on unmapped offset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            prdata  <= (acc & ~pready & ~pwrite) ? rdata : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    chk_high_vector: assert property (
        pc_load && take_hi_r |-> vec_addr == VEC_HIGH)
        else $error("high take not at high vector");

    chk_low_vector: assert property (
        pc_load && !take_hi_r |-> vec_addr == VEC_LOW)
        else $error("low take not at low vector");

    chk_high_preempt: assert property (
        (st_r == st_idle && in_low_r && hi_req) ##1 hi_req [*2]
        |=> pc_load && vec_addr == VEC_HIGH && in_high_r)
        else $error("high request did not preempt low routine");

    chk_compat_vector: assert property (
        pc_load && !$past(pm) |-> vec_addr == VEC_HIGH)
        else $error("compat take not at high vector");

    chk_enable_clear: assert property (
        pc_load && (!$past(pm) || take_hi_r) |-> !icr_r[BIT_GH])
        else $error("global enable not cleared on take");

    chk_low_blocked: assert property (
        pc_load && $past(pm) && $past(in_high_r) |-> take_hi_r)
        else $error("low taken during high routine");

    chk_push_pulse: assert property (
        pc_load |-> stack_push ##1 (!pc_load && !stack_push))
        else $error("push and load not a single pulse");

    chk_return_sets: assert property (
        return_from_interrupt_instr && !pm && !take |=> icr_r[BIT_GH])
        else $error("return did not set global enable");

    chk_take_latency: assert property (
        (st_r == st_idle && req) ##1 req [*2] |=> pc_load)
        else $error("acceptance latency not three cycles");

    chk_flag_set: assert property (
        |src_evt |=> (flag_r & $past(src_evt)) == $past(src_evt))
        else $error("event flag not set");

    chk_request_hold: assert property (
        req ##1 req |-> irq_req)
        else $error("request dropped while qualified");

endmodule

// file: tlic_core_model.sv
// core sequencer model: return pulses and stack depth
`timescale 1ns/1ps
module tlic_core_model
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ret_go,
    input  wire logic       stack_push,
    input  wire logic       pc_load,
    output logic            return_from_interrupt_instr,
    output logic [3:0]      depth
);
    // return pulse one cycle after asked; depth tracks pushes
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            return_from_interrupt_instr <= 1'b0;
            depth                       <= 4'h0;
        end
        else
        begin
            return_from_interrupt_instr <= ret_go;
            depth <= depth + {3'h0, stack_push & pc_load}
                     - {3'h0, return_from_interrupt_instr};
        end
    end
endmodule

// file: tb.sv
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
module tb;
    import tlic_pkg::*;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, src_evt;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  ext_pin;
    logic        ret_instr, irq_req, stack_push, pc_load, ret_go, e;
    logic [20:0] vec_addr;
    logic [3:0]  depth;
    int          failures, checked, n;
    logic [7:0]  ra [6] = '{ADDR_RCR, ADDR_ICR, ADDR_FLAG, ADDR_EN,
                            ADDR_PRIO, ADDR_PERI};
    logic [7:0]  rv [6] = '{RST_RCR, RST_ICR, RST_FLAG, RST_EN,
                            RST_PRIO, RST_PERI};

    tlic_ctrl dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_evt(src_evt), .ext_pin(ext_pin),
        .return_from_interrupt_instr(ret_instr), .irq_req(irq_req),
        .stack_push(stack_push), .pc_load(pc_load), .vec_addr(vec_addr));

    tlic_core_model core_u (.clk(clk), .rst_b(rst_b), .ret_go(ret_go),
        .stack_push(stack_push), .pc_load(pc_load),
        .return_from_interrupt_instr(ret_instr), .depth(depth));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20)
        begin
            k++;
            @(posedge clk);
        end
        if (k >= 20)
            failures++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, {24'h0, x});
    endtask

    task automatic evt(input logic [7:0] m);
        @(posedge clk);
        src_evt <= m;
        @(posedge clk);
        src_evt <= 8'h00;
    endtask

    task automatic ret;
        @(posedge clk);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // waits for the vector strobe and checks its companions
    task automatic wait_take(input logic [20:0] v);
        n = 0;
        @(negedge clk);
        while (pc_load !== 1'b1 && n < 40)
        begin
            n++;
            @(negedge clk);
        end
        if (n >= 40)
            failures++;
        chk({31'h0, stack_push}, 32'h1);
        chk({31'h0, irq_req}, 32'h1);
        chk({11'h0, vec_addr}, {11'h0, v});
    endtask

    task automatic no_take(input int c);
        logic seen;
        seen = 1'b0;
        repeat (c)
        begin
            @(negedge clk);
            if (pc_load !== 1'b0)
                seen = 1'b1;
        end
        chk({31'h0, seen}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize;
    end

    initial
    begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; src_evt = 8'h00;
        ext_pin = 2'b00; ret_go = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(ra[i], rv[i]);
        rd_chk(ADDR_STAT, 8'h00);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, e}, 32'h1);
        // flag rises with every enable off, then waits on gate
        evt(8'h04);
        rd_chk(ADDR_FLAG, 8'h04);
        apb(1'b1, ADDR_PRIO, 32'h00);
        apb(1'b1, ADDR_EN, 32'hff);
        apb(1'b1, ADDR_ICR, 32'h80);
        no_take(12);
        apb(1'b1, ADDR_ICR, 32'hc0);
        wait_take(VEC_HIGH);
        rd_chk(ADDR_ICR, 8'h40);
        apb(1'b1, ADDR_FLAG, 32'h04);
        rd_chk(ADDR_FLAG, 8'h00);
        ret;
        rd_chk(ADDR_ICR, 8'hc0);
        // pin edge reaches the core in bounded time
        @(posedge clk);
        ext_pin <= 2'b01;
        wait_take(VEC_HIGH);
        chk({31'h0, n <= 12}, 32'h1);
        @(posedge clk);
        ext_pin <= 2'b00;
        apb(1'b1, ADDR_FLAG, 32'h01);
        ret;
        // priority mode: both levels pending at once
        apb(1'b1, ADDR_ICR, 32'h00);
        apb(1'b1, ADDR_EN, 32'h03);
        apb(1'b1, ADDR_PRIO, 32'h01);
        apb(1'b1, ADDR_RCR, 32'h80);
        rd_chk(ADDR_RCR, 8'h80);
        apb(1'b1, ADDR_ICR, 32'hc0);
        evt(8'h03);
        wait_take(VEC_HIGH);
        rd_chk(ADDR_ICR, 8'h40);
        no_take(12);
        apb(1'b1, ADDR_FLAG, 32'h01);
        @(posedge clk);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
        wait_take(VEC_LOW);
        rd_chk(ADDR_ICR, 8'h80);
        evt(8'h01);
        wait_take(VEC_HIGH);
        rd_chk(ADDR_ICR, 8'h00);
        chk({28'h0, depth}, 32'h2);
        rd_chk(ADDR_STAT, 8'h03);
        summarize;
    end
endmodule
